// ==== hw/adc_mic_select_and_volume.v ====
// Functional notes
// - Top bit of mic control powers record channel up at 1, down at 0.
// - Source field picks mic pin: io one, bit clock, audio in, io two.
// - Enable bit feeds selected mic stream into record channel while top bit is 1; off at reset.
// - Soft-step codes: step per sample, per two samples, or immediate.
// - Mute bit silences channel at 1; resets to 1, so starts muted.
// - Three-bit fine gain, 0.1 dB attenuation steps, 000 to 100.
// - Seven-bit signed coarse gain, half-dB steps, -12 to +20 dB, resets 0.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adc_mic_regs.vh"

module adc_mic_select_and_volume
#(
  parameter ADDR_WIDTH = 12,
  parameter GAIN_WIDTH = 7
)
(
  input  wire                  aclk,
  input  wire                  aresetn,
  // AXI4-Lite slave.
  input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Record channel timing and microphone pins.
  input  wire                  sample_tick,
  input  wire                  general_io_pin_one,
  input  wire                  serial_bit_clock_pin,
  input  wire                  serial_audio_in_pin,
  input  wire                  general_io_pin_two,
  // Record channel controls.
  output reg                   channel_power_up,
  output reg                   mic_path_enable,
  output reg                   mic_stream,
  output reg                   channel_mute,
  output reg  [2:0]            fine_attenuation,
  output wire [GAIN_WIDTH-1:0] applied_coarse_gain,
  output wire                  gain_settled
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------

  localparam [2:0] SEL_RSVD_BEFORE  = 3'h0;
  localparam [2:0] SEL_MIC_CONTROL  = 3'h1;
  localparam [2:0] SEL_FINE_GAIN    = 3'h2;
  localparam [2:0] SEL_COARSE_GAIN  = 3'h3;
  localparam [2:0] SEL_RSVD_AFTER_A = 3'h4;
  localparam [2:0] SEL_RSVD_AFTER_B = 3'h5;
  localparam [2:0] SEL_GAIN_STATUS  = 3'h6;
  localparam [2:0] SEL_NONE         = 3'h7;

  // Maps a byte address onto a register select; misaligned or unknown gives none.
  function [2:0] reg_select;
    input [ADDR_WIDTH-1:0] addr;
    reg   [9:0]            word_index;
    begin
      word_index = addr[ADDR_WIDTH-1:2];
      if (addr[1:0] != 2'h0)
        reg_select = SEL_NONE;
      else
      begin
        case (word_index)
          `IDX_RSVD_BEFORE        : reg_select = SEL_RSVD_BEFORE;
          `IDX_RECORD_MIC_CONTROL : reg_select = SEL_MIC_CONTROL;
          `IDX_RECORD_FINE_GAIN   : reg_select = SEL_FINE_GAIN;
          `IDX_RECORD_COARSE_GAIN : reg_select = SEL_COARSE_GAIN;
          `IDX_RSVD_AFTER_A       : reg_select = SEL_RSVD_AFTER_A;
          `IDX_RSVD_AFTER_B       : reg_select = SEL_RSVD_AFTER_B;
          `IDX_RECORD_GAIN_STATUS : reg_select = SEL_GAIN_STATUS;
          default                 : reg_select = SEL_NONE;
        endcase
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------

  reg [7:0] record_mic_control;
  reg [7:0] record_fine_gain_mute;
  reg [7:0] record_coarse_gain;
  reg [7:0] reserved_before;
  reg [7:0] reserved_after_a;
  reg [7:0] reserved_after_b;

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------

  reg                  aw_held;
  reg                  w_held;
  reg [ADDR_WIDTH-1:0] awaddr_q;
  reg [7:0]            wdata_q;
  reg                  wlane_q;
  reg                  next_aw_held;
  reg                  next_w_held;
  reg                  next_bvalid;
  reg                  do_write;
  reg [2:0]            write_sel;

  // Address and data are caught independently, so either may arrive first.
  always @*
  begin
    do_write     = aw_held & w_held & ~s_axi_bvalid;
    write_sel    = reg_select(awaddr_q);
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_bvalid  = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready)
      next_aw_held = 1'b1;
    if (s_axi_wvalid && s_axi_wready)
      next_w_held = 1'b1;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
  end

  // Handshake flops and the captured write request.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      awaddr_q      <= {ADDR_WIDTH{1'b0}};
      wdata_q       <= 8'h00;
      wlane_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready  <= ~next_w_held;
      s_axi_bvalid  <= next_bvalid;
      if (s_axi_awvalid && s_axi_awready)
        awaddr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_write)
        s_axi_bresp <= (write_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
  end

  // Register updates; only byte lane 0 carries data, the status word ignores writes.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      record_mic_control    <= `RST_MIC_CONTROL;
      record_fine_gain_mute <= `RST_FINE_GAIN;
      record_coarse_gain    <= `RST_COARSE_GAIN;
      reserved_before       <= `RST_RESERVED;
      reserved_after_a      <= `RST_RESERVED;
      reserved_after_b      <= `RST_RESERVED;
    end
    else if (do_write && wlane_q)
    begin
      case (write_sel)
        SEL_MIC_CONTROL  : record_mic_control    <= wdata_q;
        SEL_FINE_GAIN    : record_fine_gain_mute <= wdata_q;
        SEL_COARSE_GAIN  : record_coarse_gain    <= wdata_q;
        SEL_RSVD_BEFORE  : reserved_before       <= wdata_q;
        SEL_RSVD_AFTER_A : reserved_after_a      <= wdata_q;
        SEL_RSVD_AFTER_B : reserved_after_b      <= wdata_q;
        default          : reserved_before       <= reserved_before;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------

  reg [7:0] read_byte;
  reg [2:0] read_sel;

  // Selects the byte to return; the status word shows the live gain ramp.
  always @*
  begin
    read_sel = reg_select(s_axi_araddr);
    case (read_sel)
      SEL_MIC_CONTROL  : read_byte = record_mic_control;
      SEL_FINE_GAIN    : read_byte = record_fine_gain_mute;
      SEL_COARSE_GAIN  : read_byte = record_coarse_gain;
      SEL_RSVD_BEFORE  : read_byte = reserved_before;
      SEL_RSVD_AFTER_A : read_byte = reserved_after_a;
      SEL_RSVD_AFTER_B : read_byte = reserved_after_b;
      SEL_GAIN_STATUS  : read_byte = {gain_settled, applied_coarse_gain};
      default          : read_byte = 8'h00;
    endcase
  end

  // One read at a time; the answer comes on the cycle after the address is taken.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, read_byte};
      s_axi_rresp   <= (read_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // --------------------------------------------------------------------------
  // Record channel controls
  // --------------------------------------------------------------------------

  reg selected_pin;

  // Picks the microphone pin named by the source field.
  always @*
  begin
    case (record_mic_control[`MIC_SOURCE_HI:`MIC_SOURCE_LO])
      `SRC_GENERAL_IO_ONE   : selected_pin = general_io_pin_one;
      `SRC_SERIAL_BIT_CLOCK : selected_pin = serial_bit_clock_pin;
      `SRC_SERIAL_AUDIO_IN  : selected_pin = serial_audio_in_pin;
      default               : selected_pin = general_io_pin_two;
    endcase
  end

  // Drives the channel controls; the stream is forced low unless the path is enabled and the channel is powered up.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      channel_power_up <= 1'b0;
      mic_path_enable  <= 1'b0;
      mic_stream       <= 1'b0;
      channel_mute     <= 1'b1;
      fine_attenuation <= 3'h0;
    end
    else
    begin
      channel_power_up <= record_mic_control[`MIC_POWER_BIT];
      mic_path_enable  <= record_mic_control[`MIC_ENABLE_BIT];
      mic_stream       <= record_mic_control[`MIC_ENABLE_BIT] &
                          record_mic_control[`MIC_POWER_BIT] &
                          selected_pin;
      channel_mute     <= record_fine_gain_mute[`MUTE_BIT];
      fine_attenuation <= record_fine_gain_mute[`FINE_GAIN_HI:`FINE_GAIN_LO];
    end
  end

  // --------------------------------------------------------------------------
  // Coarse gain ramp
  // --------------------------------------------------------------------------

  // Moves the applied gain toward the programmed coarse value at the chosen pace.
  gain_stepper
  #(
    .GAIN_WIDTH (GAIN_WIDTH)
  )
  u_gain_stepper
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .sample_tick  (sample_tick),
    .step_mode    (record_mic_control[`STEP_MODE_HI:`STEP_MODE_LO]),
    .target_gain  (record_coarse_gain[`COARSE_GAIN_HI:`COARSE_GAIN_LO]),
    .applied_gain (applied_coarse_gain),
    .gain_settled (gain_settled)
  );

endmodule // adc_mic_select_and_volume

`default_nettype wire

// ==== hw/adc_mic_regs.vh ====
`ifndef ADC_MIC_REGS_VH
`define ADC_MIC_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_RSVD_BEFORE        10'h050
`define IDX_RECORD_MIC_CONTROL 10'h051
`define IDX_RECORD_FINE_GAIN   10'h052
`define IDX_RECORD_COARSE_GAIN 10'h053
`define IDX_RSVD_AFTER_A       10'h054
`define IDX_RSVD_AFTER_B       10'h055
`define IDX_RECORD_GAIN_STATUS 10'h056

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MIC_POWER_BIT          7
`define MIC_SOURCE_HI          5
`define MIC_SOURCE_LO          4
`define MIC_ENABLE_BIT         3
`define STEP_MODE_HI           1
`define STEP_MODE_LO           0
`define MUTE_BIT               7
`define FINE_GAIN_HI           6
`define FINE_GAIN_LO           4
`define COARSE_GAIN_HI         6
`define COARSE_GAIN_LO         0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_MIC_CONTROL        8'h00
`define RST_FINE_GAIN          8'h80
`define RST_COARSE_GAIN        8'h00
`define RST_RESERVED           8'h00

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define SRC_GENERAL_IO_ONE     2'h0
`define SRC_SERIAL_BIT_CLOCK   2'h1
`define SRC_SERIAL_AUDIO_IN    2'h2
`define SRC_GENERAL_IO_TWO     2'h3
`define STEP_EVERY_SAMPLE      2'h0
`define STEP_EVERY_TWO         2'h1
`define STEP_IMMEDIATE         2'h2
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

// ==== hw/gain_stepper.v ====
`timescale 1ns/1ps
`default_nettype none
`include "adc_mic_regs.vh"

module gain_stepper
#(
  parameter GAIN_WIDTH = 7
)
(
  input  wire                  aclk,
  input  wire                  aresetn,
  input  wire                  sample_tick,
  input  wire [1:0]            step_mode,
  input  wire [GAIN_WIDTH-1:0] target_gain,
  output reg  [GAIN_WIDTH-1:0] applied_gain,
  output reg                   gain_settled
);

  // --------------------------------------------------------------------------
  // Stepping interval
  // --------------------------------------------------------------------------

  reg                  tick_phase;
  reg                  step_now;
  reg [GAIN_WIDTH-1:0] next_applied_gain;

  // Phase toggles on every sample tick so that the slow mode steps on every other one.
  always @(posedge aclk)
  begin
    if (!aresetn)
      tick_phase <= 1'b0;
    else if (sample_tick)
      tick_phase <= ~tick_phase;
  end

  // --------------------------------------------------------------------------
  // Gain ramp
  // --------------------------------------------------------------------------

  // Chooses the next applied gain; the comparison is two's complement.
  always @*
  begin
    next_applied_gain = applied_gain;
    step_now          = 1'b0;
    case (step_mode)
      `STEP_EVERY_SAMPLE : step_now = sample_tick;
      `STEP_EVERY_TWO    : step_now = sample_tick & tick_phase;
      default            : step_now = 1'b0;
    endcase
    if (step_mode == `STEP_IMMEDIATE || step_mode == 2'h3)
      next_applied_gain = target_gain;
    else if (step_now && $signed(applied_gain) < $signed(target_gain))
      next_applied_gain = applied_gain + {{(GAIN_WIDTH-1){1'b0}}, 1'b1};
    else if (step_now && $signed(applied_gain) > $signed(target_gain))
      next_applied_gain = applied_gain - {{(GAIN_WIDTH-1){1'b0}}, 1'b1};
  end

  // Holds the applied gain and flags when it has reached the programmed value.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      applied_gain <= {GAIN_WIDTH{1'b0}};
      gain_settled <= 1'b1;
    end
    else
    begin
      applied_gain <= next_applied_gain;
      gain_settled <= (next_applied_gain == target_gain);
    end
  end

endmodule // gain_stepper

`default_nettype wire

// ==== testbench/adc_mic_checker_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Bus timing and record channel control checks.
// ----------------------------------------------------------------------
module adc_mic_checker
#(
  parameter ADDR_WIDTH = 12
)
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic                  channel_power_up,
  input wire logic                  mic_path_enable,
  input wire logic                  mic_stream,
  input wire logic                  channel_mute,
  input wire logic                  gain_settled
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Address and data of a write taken at one edge.
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_aw_drop;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  property p_wr_resp;
    s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rd_resp;
    s_rd_taken |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == '0) |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  property p_stream_gate;
    mic_stream |-> channel_power_up && mic_path_enable;
  endproperty
  property p_reset_state;
    $rose(aresetn) |-> channel_mute && !channel_power_up && !mic_path_enable && gain_settled;
  endproperty
  property p_ctrl_cause;
    $changed(channel_power_up) || $changed(channel_mute) |-> $past(s_axi_bvalid);
  endproperty

  a_aw_drop: assert property (p_aw_drop) else $error("awready stayed high after address taken");
  a_wr_resp: assert property (p_wr_resp) else $error("write response not two cycles after take");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped before bready");
  a_rd_resp: assert property (p_rd_resp) else $error("read data not one cycle after take");
  a_r_hold: assert property (p_r_hold) else $error("read response changed before rready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_stream_gate: assert property (p_stream_gate) else $error("stream while path off");
  a_reset_state: assert property (p_reset_state) else $error("wrong state out of reset");
  a_ctrl_cause: assert property (p_ctrl_cause) else $error("control moved without write");
endmodule // adc_mic_checker

bind adc_mic_select_and_volume adc_mic_checker #(.ADDR_WIDTH(ADDR_WIDTH)) adc_mic_checker_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .channel_power_up(channel_power_up), .mic_path_enable(mic_path_enable),
  .mic_stream(mic_stream), .channel_mute(channel_mute), .gain_settled(gain_settled));

`default_nettype wire

// ==== testbench/mic_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Digital microphone streams on the four candidate pins.
// ----------------------------------------------------------------------
module mic_model
(
  input  wire logic aclk,
  output wire logic io_one,
  output wire logic bit_clk,
  output wire logic audio_in,
  output wire logic io_two
);
  logic [7:0] lfsr = 8'h5a;

  // Every pin carries a different tap of one shared LFSR, which shifts each cycle.
  always @(posedge aclk)
  begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  end
  assign io_one   = lfsr[0];
  assign bit_clk  = lfsr[2];
  assign audio_in = lfsr[5];
  assign io_two   = lfsr[7];
endmodule // mic_model

`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Register bus tests of the record channel controls.
// ----------------------------------------------------------------------
module tb;
  logic            aclk = 1'b0;
  logic            aresetn = 1'b0;
  logic [11:0]     awaddr = 12'h0;
  logic [11:0]     araddr = 12'h0;
  logic [31:0]     wdata = 32'h0;
  logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic            arvalid = 1'b0, rready = 1'b0, tick = 1'b0;
  wire logic       awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic       io_one, bit_clk, audio_in, io_two;
  wire logic       pwr, en, stream, mute, settled;
  wire logic [2:0] fine;
  wire logic [6:0] gain;
  logic [3:0]      pins_q;
  logic [31:0]     rd;
  logic [1:0]      resp;
  logic [6:0]      cur = 7'h0;
  logic [7:0]      rst_val [3] = '{8'h00, 8'h80, 8'h00};
  int              bad_count = 0, checks_done = 0, tick_n = 0, s;

  adc_mic_select_and_volume #(.ADDR_WIDTH(12), .GAIN_WIDTH(7)) adc_mic_select_and_volume_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_tick(tick), .general_io_pin_one(io_one), .serial_bit_clock_pin(bit_clk),
    .serial_audio_in_pin(audio_in), .general_io_pin_two(io_two), .channel_power_up(pwr),
    .mic_path_enable(en), .mic_stream(stream), .channel_mute(mute),
    .fine_attenuation(fine), .applied_coarse_gain(gain), .gain_settled(settled));

  mic_model mic_model_i (.aclk(aclk), .io_one(io_one), .bit_clk(bit_clk),
    .audio_in(audio_in), .io_two(io_two));

  // Clock and the pin values one edge back.
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    pins_q <= {io_two, audio_in, bit_clk, io_one};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One write (w=1) or read; holds each channel until its handshake.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int  i;
    logic done;
    done = 1'b0;
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h0, d};
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    for (i = 0; i < 50 && !done; i++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if ((bvalid && bready) || (rvalid && rready))
      begin
        rd = rdata;
        resp = w ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
    begin
      bad_count++;
      results();
    end
    @(posedge aclk);
  endtask

  // Sets mode and target, then pulses ticks and follows the ramp.
  task automatic ramp(input logic [1:0] mode, input logic [6:0] tgt, input int n);
    int i;
    xfer(1'b1, 12'h144, {6'h0, mode});
    xfer(1'b1, 12'h14c, {1'b0, tgt});
    if (mode == 2'h2)
      cur = tgt;
    chk(gain, cur);
    chk(settled, cur == tgt);
    for (i = 0; i < n; i++)
    begin
      tick_n++;
      if (cur != tgt && (mode == 2'h0 || tick_n % 2 == 0))
        cur = ($signed(tgt) > $signed(cur)) ? cur + 7'h1 : cur - 7'h1;
      tick <= 1'b1;
      @(posedge aclk);
      tick <= 1'b0;
      @(posedge aclk);
      chk(gain, cur);
    end
    chk(settled, cur == tgt);
  endtask

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(mute, 1'b1);
    for (s = 0; s < 3; s++)
    begin
      xfer(1'b0, 12'h144 + 12'(4 * s), 8'h0);
      chk(rd, rst_val[s]);
    end
    for (s = 0; s < 4; s++)
    begin
      xfer(1'b1, 12'h144, {2'b10, s[1:0], 4'h8});
      chk(pwr & en, 1'b1);
      repeat (4)
      begin
        @(posedge aclk);
        chk(stream, pins_q[s]);
      end
    end
    xfer(1'b1, 12'h144, 8'h80);
    repeat (4)
    begin
      @(posedge aclk);
      chk({pwr, en, stream}, 3'b100);
    end
    xfer(1'b1, 12'h144, 8'h08);
    repeat (4)
    begin
      @(posedge aclk);
      chk({pwr, en, stream}, 3'b010);
    end
    for (s = 0; s < 5; s++)
    begin
      xfer(1'b1, 12'h148, {1'b0, s[2:0], 4'h0});
      chk({mute, fine}, s[2:0]);
    end
    xfer(1'b1, 12'h148, 8'hc0);
    xfer(1'b0, 12'h148, 8'h0);
    chk({mute, fine}, 4'hc);
    chk(rd, 32'hc0);
    ramp(2'h2, 7'h68, 0);
    ramp(2'h2, 7'h28, 0);
    ramp(2'h0, 7'h25, 4);
    ramp(2'h1, 7'h28, 6);
    xfer(1'b0, 12'h14c, 8'h0);
    chk(rd, 32'h28);
    xfer(1'b0, 12'h158, 8'h0);
    chk(rd, 32'ha8);
    xfer(1'b1, 12'h140, 8'h00);
    chk(resp, 2'h0);
    xfer(1'b1, 12'h000, 8'h55);
    chk(resp, 2'h2);
    xfer(1'b0, 12'h000, 8'h0);
    chk(resp, 2'h2);
    chk(rd, 32'h0);
    xfer(1'b0, 12'h145, 8'h0);
    chk(resp, 2'h2);
    results();
  end
endmodule // tb

`default_nettype wire
